// file: rtl/dscc_clock_control.v
// Purpose: Standard / double-speed clock control with per-peripheral selects
// Assumes: CLK samples the crystal period strobe; SFR bus synchronous to CLK
// Notes: Whole-byte SFR writes only; reads return registered data
`timescale 1ns/1ps
`default_nettype none
`include "dscc_consts.vh"

module dscc_clock_control (
	input wire CLK,
	input wire SYS_RST,
	input wire CE,
	input wire CRYSTAL_INPUT,
	input wire SECURITY_DOUBLE,
	input wire SFR_WR,
	input wire SFR_RD,
	input wire [7:0] SFR_ADDR,
	input wire [7:0] SFR_WDATA,
	input wire [1:0] UART_MODE,
	output reg [7:0] SFR_RDATA,
	output reg SFR_HIT,
	output reg CORE_DOUBLE_ACTIVE,
	output reg CORE_TICK,
	output reg [7:0] PERIPH_FAST,
	output reg [7:0] PERIPH_TICK
);
	// ----------------------------------------
	// Helper functions
	// ----------------------------------------
	function eff_fast;
		input double;
		input sel;
		begin
			eff_fast = double & ~sel;
		end
	endfunction

	// ----------------------------------------
	// Register state
	// ----------------------------------------
	reg core_double_speed;
	reg strap_pending;
	reg two_wire_speed_select;
	reg watchdog_speed_select;
	reg counter_array_speed_select;
	reg uart_speed_select;
	reg timer_two_speed_select;
	reg timer_one_speed_select;
	reg timer_zero_speed_select;
	reg spi_speed_select;
	reg [6:0] reserved_bits;
	reg half_clk;
	reg xtal_prev;
	reg double_applied;
	wire xtal_rise;
	wire half_rise;
	wire osc_en;
	wire core_fast_unused;
	wire [7:0] core_image;
	wire [7:0] serial_image;
	wire [7:0] next_fast;
	wire [7:0] per_tick;
	wire core_tick_w;
	wire uart_fixed_mode;

	assign core_image = {two_wire_speed_select, watchdog_speed_select,
		counter_array_speed_select, uart_speed_select, timer_two_speed_select,
		timer_one_speed_select, timer_zero_speed_select, core_double_speed};
	assign serial_image = {reserved_bits, spi_speed_select};

	// ----------------------------------------
	// Register writes, reset and strap load
	// ----------------------------------------
	always @(posedge CLK) begin
		if (SYS_RST) begin
			core_double_speed <= 1'b0;
			strap_pending <= 1'b1;
			{two_wire_speed_select, watchdog_speed_select, counter_array_speed_select,
				uart_speed_select, timer_two_speed_select, timer_one_speed_select,
				timer_zero_speed_select} <= `DSCC_CORE_RST;
			spi_speed_select <= `DSCC_SPI_RST;
			reserved_bits <= 7'h00;
		end else if (CE) begin
			if (strap_pending) begin
				strap_pending <= 1'b0;
				core_double_speed <= SECURITY_DOUBLE;
			end else if (SFR_WR && SFR_ADDR == `DSCC_ADDR_CORE) begin
				// Whole byte only; selects stored even in standard mode
				{two_wire_speed_select, watchdog_speed_select, counter_array_speed_select,
					uart_speed_select, timer_two_speed_select, timer_one_speed_select,
					timer_zero_speed_select} <= SFR_WDATA[7:1];
				core_double_speed <= SFR_WDATA[`DSCC_BIT_DOUBLE];
			end
			if (SFR_WR && SFR_ADDR == `DSCC_ADDR_SERIAL) begin
				spi_speed_select <= SFR_WDATA[`DSCC_BIT_SPI];
				reserved_bits <= SFR_WDATA[7:1];
			end
		end
	end

	// ----------------------------------------
	// Crystal divider and glitch-free switch
	// ----------------------------------------
	assign xtal_rise = CRYSTAL_INPUT & ~xtal_prev;
	assign half_rise = xtal_rise & ~half_clk;

	always @(posedge CLK) begin
		if (SYS_RST) begin
			xtal_prev <= 1'b0;
			half_clk <= 1'b0;
			double_applied <= 1'b0;
		end else if (CE) begin
			xtal_prev <= CRYSTAL_INPUT;
			if (xtal_rise)
				half_clk <= ~half_clk;
			if (half_rise)
				double_applied <= core_double_speed;
		end
	end

	// Divider bypassed in double-speed: every crystal period counts
	assign osc_en = double_applied ? xtal_rise : half_rise;
	// Core counts 6 enabled periods; halved input makes 12 crystal periods
	assign core_fast_unused = 1'b1;

	dscc_phase_gen u_core (
		.clk(CLK),
		.rst(SYS_RST),
		.ce(CE),
		.osc_en(osc_en),
		.fast(core_fast_unused),
		.tick(core_tick_w)
	);

	// ----------------------------------------
	// Peripheral speed selects
	// ----------------------------------------
	// UART select acts only in modes 0 and 2
	assign uart_fixed_mode = (UART_MODE == 2'h0) || (UART_MODE == 2'h2);

	assign next_fast[0] = eff_fast(double_applied, timer_zero_speed_select);
	assign next_fast[1] = eff_fast(double_applied, timer_one_speed_select);
	assign next_fast[2] = eff_fast(double_applied, timer_two_speed_select);
	assign next_fast[3] = eff_fast(double_applied, uart_speed_select) & uart_fixed_mode;
	assign next_fast[4] = eff_fast(double_applied, counter_array_speed_select);
	assign next_fast[5] = eff_fast(double_applied, watchdog_speed_select);
	assign next_fast[6] = eff_fast(double_applied, two_wire_speed_select);
	assign next_fast[7] = eff_fast(double_applied, spi_speed_select);

	// Peripheral counters use the raw crystal strobe: 6 or 12 periods
	genvar gi;
	generate
		for (gi = 0; gi < 8; gi = gi + 1) begin : g_per
			dscc_phase_gen u_per (
				.clk(CLK),
				.rst(SYS_RST),
				.ce(CE),
				.osc_en(xtal_rise),
				.fast(next_fast[gi]),
				.tick(per_tick[gi])
			);
		end
	endgenerate

	// ----------------------------------------
	// Registered outputs and read port
	// ----------------------------------------
	always @(posedge CLK) begin
		if (SYS_RST) begin
			SFR_RDATA <= 8'h00;
			SFR_HIT <= 1'b0;
			CORE_DOUBLE_ACTIVE <= 1'b0;
			CORE_TICK <= 1'b0;
			PERIPH_FAST <= 8'h00;
			PERIPH_TICK <= 8'h00;
		end else if (CE) begin
			CORE_DOUBLE_ACTIVE <= double_applied;
			CORE_TICK <= core_tick_w;
			PERIPH_FAST <= next_fast;
			PERIPH_TICK <= per_tick;
			SFR_HIT <= SFR_RD && (SFR_ADDR == `DSCC_ADDR_CORE || SFR_ADDR == `DSCC_ADDR_SERIAL);
			if (SFR_RD && SFR_ADDR == `DSCC_ADDR_CORE)
				SFR_RDATA <= core_image;
			else if (SFR_RD && SFR_ADDR == `DSCC_ADDR_SERIAL)
				SFR_RDATA <= serial_image;
			else
				SFR_RDATA <= 8'h00;
		end
	end
endmodule // dscc_clock_control
`default_nettype wire

// file: rtl/dscc_consts.vh
// Purpose: Constants of the double-speed clock control block
// Assumes: Special-function-register addresses are 8 bits
// Notes: Included by the clock control design files
`ifndef DSCC_CONSTS_VH
`define DSCC_CONSTS_VH

// ----------------------------------------
// Register addresses
// ----------------------------------------
`define DSCC_ADDR_CORE 8'h8f
`define DSCC_ADDR_SERIAL 8'haf

// ----------------------------------------
// Field positions, core and serial speed registers
// ----------------------------------------
`define DSCC_BIT_DOUBLE 0
`define DSCC_BIT_TIMER0 1
`define DSCC_BIT_TIMER1 2
`define DSCC_BIT_TIMER2 3
`define DSCC_BIT_UART 4
`define DSCC_BIT_PCA 5
`define DSCC_BIT_WDOG 6
`define DSCC_BIT_TWI 7
`define DSCC_BIT_SPI 0

// ----------------------------------------
// Reset values and timing counts
// ----------------------------------------
`define DSCC_CORE_RST 7'h00
`define DSCC_SPI_RST 1'b0
`define DSCC_PER_STD 4'hc
`define DSCC_PER_FAST 4'h6

`endif

// file: rtl/dscc_phase_gen.v
// Purpose: Cycle phase generator for one clock consumer
// Assumes: Enable strobe marks each oscillator period used
// Notes: Emits a one-cycle tick every 6 or 12 enabled periods
`timescale 1ns/1ps
`default_nettype none
`include "dscc_consts.vh"

module dscc_phase_gen (
	input wire clk,
	input wire rst,
	input wire ce,
	input wire osc_en,
	input wire fast,
	output reg tick
);
	reg [3:0] count;
	wire [3:0] last;

	assign last = fast ? (`DSCC_PER_FAST - 4'h1) : (`DSCC_PER_STD - 4'h1);

	// ----------------------------------------
	// Period counter
	// ----------------------------------------
	always @(posedge clk) begin
		if (rst) begin
			count <= 4'h0;
			tick <= 1'b0;
		end else if (ce) begin
			tick <= 1'b0;
			if (osc_en) begin
				if (count >= last) begin
					count <= 4'h0;
					tick <= 1'b1;
				end else begin
					count <= count + 4'h1;
				end
			end
		end
	end
endmodule // dscc_phase_gen
`default_nettype wire

// file: verification/dscc_clock_control_bench.sv
// Purpose: Self-checking bench for the clock control block
// Assumes: Crystal period of four CLK cycles
// Notes: Rows give speed register pairs
`timescale 1ns/1ps
`default_nettype none
`include "dscc_consts.vh"
module dscc_clock_control_bench;
	logic CLK = 0, SYS_RST = 1, CE = 1, CRYSTAL_INPUT = 0, SECURITY_DOUBLE = 0;
	logic SFR_WR = 0, SFR_RD = 0, SFR_HIT, CORE_DOUBLE_ACTIVE, CORE_TICK;
	logic [7:0] SFR_ADDR = 8'h00, SFR_WDATA = 8'h00, SFR_RDATA, PERIPH_FAST, PERIPH_TICK;
	logic [1:0] UART_MODE = 2'h0;
	logic [15:0] rows [6] = '{16'h0101, 16'h01ff, 16'h0013, 16'h80fe, 16'h0000, 16'h0055};
	int mismatches = 0, n_checks = 0, ph = 0, i, n, g;
	dscc_clock_control u_dscc_clock_control (.CLK(CLK), .SYS_RST(SYS_RST), .CE(CE),
		.CRYSTAL_INPUT(CRYSTAL_INPUT), .SECURITY_DOUBLE(SECURITY_DOUBLE), .SFR_WR(SFR_WR),
		.SFR_RD(SFR_RD), .SFR_ADDR(SFR_ADDR), .SFR_WDATA(SFR_WDATA), .UART_MODE(UART_MODE),
		.SFR_RDATA(SFR_RDATA), .SFR_HIT(SFR_HIT), .CORE_DOUBLE_ACTIVE(CORE_DOUBLE_ACTIVE),
		.CORE_TICK(CORE_TICK), .PERIPH_FAST(PERIPH_FAST), .PERIPH_TICK(PERIPH_TICK));
	initial begin
		forever #4 CLK = ~CLK;
	end
	always @(posedge CLK) begin
		ph <= ph + 1;
		CRYSTAL_INPUT <= ph[1];
	end
	task conclude;
		$display("checks %0d mismatches %0d", n_checks, mismatches);
		if (mismatches == 0 && n_checks > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask
	task chk(input logic [7:0] got, input logic [7:0] exp);
		n_checks++;
		if (got !== exp) begin
			mismatches++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge CLK);
		SFR_WR <= 1;
		SFR_ADDR <= a;
		SFR_WDATA <= d;
		@(posedge CLK);
		SFR_WR <= 0;
	endtask
	task rd(input logic [7:0] a, input logic [7:0] e);
		@(posedge CLK);
		SFR_RD <= 1;
		SFR_ADDR <= a;
		@(posedge CLK);
		SFR_RD <= 0;
		#1 chk(SFR_RDATA, e);
		chk({7'h0, SFR_HIT}, {7'h0, (a == `DSCC_ADDR_CORE || a == `DSCC_ADDR_SERIAL)});
	endtask
	task rst(input logic s);
		SECURITY_DOUBLE <= s;
		SYS_RST <= 1;
		repeat (8) @(posedge CLK);
		SYS_RST <= 0;
		#1 chk({PERIPH_TICK[0], CORE_TICK, SFR_RDATA[5:0]}, 8'h00);
		repeat (2) @(posedge CLK);
	endtask
	task settle(input logic d);
		for (n = 0; n < 40 && CORE_DOUBLE_ACTIVE !== d; n++) @(posedge CLK);
		chk({7'h0, CORE_DOUBLE_ACTIVE}, {7'h0, d});
		repeat (2) @(posedge CLK);
		#1;
	endtask
	task gap(input int w, output int g);
		for (n = 0; n < 200 && (w == 8 ? CORE_TICK : PERIPH_TICK[w]) !== 1'b1; n++) @(posedge CLK);
		@(posedge CLK);
		for (g = 1; g < 200 && (w == 8 ? CORE_TICK : PERIPH_TICK[w]) !== 1'b1; g++) @(posedge CLK);
		if (g >= 200) begin
			mismatches++;
			conclude();
		end
	endtask
	function logic [7:0] ef(input logic [15:0] r, input logic [1:0] um);
		logic [7:0] e;
		e = r[0] ? ~{r[8], r[7:1]} : 8'h00;
		e[3] = e[3] & !um[0];
		return e;
	endfunction
	initial begin
		rst(0);
		for (i = 0; i < 6; i++) begin
			UART_MODE <= i[1:0];
			wr(`DSCC_ADDR_SERIAL, rows[i][15:8]);
			wr(`DSCC_ADDR_CORE, rows[i][7:0]);
			settle(rows[i][0]);
			chk(PERIPH_FAST, ef(rows[i], i[1:0]));
			rd(`DSCC_ADDR_CORE, rows[i][7:0]);
			rd(`DSCC_ADDR_SERIAL, rows[i][15:8]);
			gap(8, g);
			chk(g[7:0], rows[i][0] ? 8'd24 : 8'd48);
			gap(0, g);
			chk(g[7:0], (rows[i][0] && !rows[i][1]) ? 8'd24 : 8'd48);
		end
		rd(8'h8e, 8'h00);
		rst(1);
		settle(1);
		rd(`DSCC_ADDR_CORE, 8'h01);
		rd(`DSCC_ADDR_SERIAL, 8'h00);
		conclude();
	end
endmodule // dscc_clock_control_bench
`default_nettype wire

// file: verification/dscc_clock_control_monitor.sv
// Purpose: Port checker for the clock control block
// Assumes: CE held high while traffic runs
// Notes: Attached to every instance by bind
`timescale 1ns/1ps
`default_nettype none
module dscc_clock_control_monitor (
	input wire logic CLK,
	input wire logic SYS_RST,
	input wire logic CE,
	input wire logic [7:0] SFR_ADDR,
	input wire logic SFR_RD,
	input wire logic [1:0] UART_MODE,
	input wire logic [7:0] SFR_RDATA,
	input wire logic SFR_HIT,
	input wire logic CORE_DOUBLE_ACTIVE,
	input wire logic CORE_TICK,
	input wire logic [7:0] PERIPH_FAST,
	input wire logic [7:0] PERIPH_TICK
);
	default clocking @(posedge CLK); endclocking
	default disable iff (SYS_RST);
	wire logic mapped = SFR_ADDR == 8'h8f || SFR_ADDR == 8'haf;
	property p_rst;
		disable iff (1'b0) SYS_RST |=> SFR_RDATA == 8'h00 && !CORE_TICK && PERIPH_TICK == 8'h00;
	endproperty
	a_rst: assert property (p_rst) else $error("outputs not cleared");
	property p_hit; SFR_RD && CE && mapped |=> SFR_HIT; endproperty
	a_hit: assert property (p_hit) else $error("mapped read missed");
	property p_miss; SFR_RD && CE && !mapped |=> !SFR_HIT && SFR_RDATA == 8'h00; endproperty
	a_miss: assert property (p_miss) else $error("unmapped read answered");
	property p_idle; CE && !SFR_RD |=> SFR_RDATA == 8'h00 && !SFR_HIT; endproperty
	a_idle: assert property (p_idle) else $error("read data without read");
	property p_std; !CORE_DOUBLE_ACTIVE [*2] |-> PERIPH_FAST == 8'h00; endproperty
	a_std: assert property (p_std) else $error("fast peripheral in standard mode");
	property p_uart; UART_MODE[0] [*2] |-> !PERIPH_FAST[3]; endproperty
	a_uart: assert property (p_uart) else $error("uart fast in mode 1 or 3");
	property p_ctick; CORE_TICK |=> !CORE_TICK [*8]; endproperty
	a_ctick: assert property (p_ctick) else $error("core tick too close");
	property p_ptick; PERIPH_TICK[7] |=> !PERIPH_TICK[7] [*8]; endproperty
	a_ptick: assert property (p_ptick) else $error("spi tick too close");
	c_hit: cover property (SFR_HIT);
	c_dbl: cover property ($rose(CORE_DOUBLE_ACTIVE));
	c_fast: cover property (PERIPH_FAST[7]);
endmodule // dscc_clock_control_monitor
bind dscc_clock_control dscc_clock_control_monitor u_dscc_clock_control_monitor (.CLK(CLK),
	.SYS_RST(SYS_RST), .CE(CE), .SFR_ADDR(SFR_ADDR), .SFR_RD(SFR_RD), .UART_MODE(UART_MODE),
	.SFR_RDATA(SFR_RDATA), .SFR_HIT(SFR_HIT), .CORE_DOUBLE_ACTIVE(CORE_DOUBLE_ACTIVE),
	.CORE_TICK(CORE_TICK), .PERIPH_FAST(PERIPH_FAST), .PERIPH_TICK(PERIPH_TICK));
`default_nettype wire
